// ---- vadmmu_top.sv ----
// mmu front end: area decode, fixed mapping, lookup sequencing, registers
//
// Functional notes
// - privileged space splits into five areas
// - low and high translated areas use buffer
// - translated areas follow cache write policy setting
// - cached fixed area clears address bit 31
// - cached fixed area caching follows cache setup
// - uncached fixed area clears bits 31 to 29
// - uncached fixed area is never cached
// - fixed areas never touch buffer or miss
// - topmost area is uncached peripheral control space
// - user mode sees lower half, translated
// - hit takes physical address and page info
// - not registered page raises translation miss
// - translation off passes address through unchanged
// - physical space is 29 bits, aliases merge
// - cache tag address has top bits cleared
// - control bit picks single or multiple spaces
// - eight-bit process tag lives in entry high
// - changing process tag needs no buffer purge
// - both resets initialise translation control (all but space select) and privilege bit; entry, base and fault registers stay undefined
// - control register resets zero except space select
// - privilege bit set on reset, cleared on return
`include "vadmmu_defines.svh"
`default_nettype none

module vadmmu_top
  import vadmmu_pkg::*;
(
  // clock and reset (power-on and manual reset merged upstream)
  input  wire logic                      clk_i,
  input  wire logic                      rst_n_i,
  // cpu request
  input  wire logic                      req_i,
  input  wire logic [31:0]               va_i,
  input  wire logic                      wr_i,
  input  wire logic [31:0]               wdata_i,
  input  wire logic                      exc_entry_i,
  input  wire logic                      exc_return_i,
  // cpu answer
  output logic                           ready_o,
  output logic                           resp_valid_o,
  output logic [`VADMMU_PA_W-1:0]        pa_o,
  output logic                           cacheable_o,
  output logic                           write_through_o,
  output logic [31:0]                    cache_tag_addr_o,
  output logic                           tlb_miss_o,
  output logic                           addr_err_o,
  output logic                           ctrl_space_o,
  output logic [31:0]                    rdata_o,
  output logic                           privileged_o,
  // cache_setup_register fields
  input  wire logic                      cache_enable_i,
  input  wire logic                      cache_wt_i,
  input  wire logic                      p1_copy_back_i,
  // translation buffer port
  output logic                           tlb_lookup_o,
  output logic [`VADMMU_VPN_W-1:0]       tlb_vpn_o,
  output logic [`VADMMU_TAG_W-1:0]       tlb_tag_o,
  output logic                           tlb_single_space_o,
  output logic                           tlb_index_xor_o,
  output logic                           tlb_flush_o,
  input  wire logic                      tlb_ack_i,
  input  wire logic                      tlb_hit_i,
  input  wire logic [31:0]               tlb_pa_i,
  input  wire logic                      tlb_cacheable_i
);

  // ========================================================================
  // declarations
  vadmmu_state_type          state;
  vadmmu_state_type          next_state;
  vadmmu_area_type           area;
  logic [31:0]               va_hold;
  logic                      at_enable;
  logic [`VADMMU_VPN_W-1:0]  page_entry_high_vpn;
  logic [31:0]               page_entry_low;
  logic [31:0]               table_base_pointer;
  logic [31:0]               fault_address_capture;
  logic                      accept;
  logic                      reg_hit;
  logic                      translated;
  logic                      reg_wr;
  logic                      next_resp;
  logic [31:0]               next_pa;
  logic                      next_cache;
  logic                      next_wt;
  logic                      next_miss;
  logic                      next_err;
  logic                      next_ctrl;
  logic [31:0]               next_rdata;
  logic [31:0]               rd_mux;
  logic                      sel_tctrl;
  logic                      sel_page_entry_high;
  logic                      sel_page_entry_low;
  logic                      sel_ttb;
  logic                      sel_tea;

  // full offsets held as constants so their low bits can be sliced legally
  localparam logic [31:0]    OFF_TCTRL = `VADMMU_OFF_TCTRL;
  localparam logic [31:0]    OFF_PAGE_ENTRY_HIGH  = `VADMMU_OFF_PAGE_ENTRY_HIGH;
  localparam logic [31:0]    OFF_PAGE_ENTRY_LOW  = `VADMMU_OFF_PAGE_ENTRY_LOW;
  localparam logic [31:0]    OFF_TTB   = `VADMMU_OFF_TTB;
  localparam logic [31:0]    OFF_TEA   = `VADMMU_OFF_TEA;

  // ========================================================================
  // area classification
  vadmmu_area_decode u_decode (
    .va_i         (va_i),
    .privileged_i (privileged_o),
    .area_o       (area)
  );

  assign accept     = req_i && ready_o;
  // registers sit in control space, matched on the low address bits
  assign sel_tctrl  = (va_i[`VADMMU_DEC_W-1:0] == OFF_TCTRL[`VADMMU_DEC_W-1:0]);
  assign sel_page_entry_high   = (va_i[`VADMMU_DEC_W-1:0] == OFF_PAGE_ENTRY_HIGH[`VADMMU_DEC_W-1:0]);
  assign sel_page_entry_low   = (va_i[`VADMMU_DEC_W-1:0] == OFF_PAGE_ENTRY_LOW[`VADMMU_DEC_W-1:0]);
  assign sel_ttb    = (va_i[`VADMMU_DEC_W-1:0] == OFF_TTB[`VADMMU_DEC_W-1:0]);
  assign sel_tea    = (va_i[`VADMMU_DEC_W-1:0] == OFF_TEA[`VADMMU_DEC_W-1:0]);
  assign reg_hit    = (area == AREA_P4) &&
                      (sel_tctrl || sel_page_entry_high || sel_page_entry_low || sel_ttb || sel_tea);
  assign translated = at_enable &&
                      ((area == AREA_P0) || (area == AREA_P3) || (area == AREA_U0));
  assign reg_wr     = accept && (state == ST_IDLE) && reg_hit && wr_i;

  // ========================================================================
  // register read mux; unused bits read zero
  always_comb begin
    rd_mux = 32'h00000000;
    if (sel_tctrl) begin
      rd_mux[`VADMMU_AT_BIT] = at_enable;
      rd_mux[`VADMMU_SV_BIT] = tlb_single_space_o;
      rd_mux[`VADMMU_IX_BIT] = tlb_index_xor_o;
    end else if (sel_page_entry_high) begin
      rd_mux = {page_entry_high_vpn, 2'h0, tlb_tag_o};
    end else if (sel_page_entry_low) begin
      rd_mux = page_entry_low;
    end else if (sel_ttb) begin
      rd_mux = table_base_pointer;
    end else if (sel_tea) begin
      rd_mux = fault_address_capture;
    end
  end

  // ========================================================================
  // next answer; fixed areas answer at once, translated ones wait on lookup
  always_comb begin
    next_state = state;
    next_resp  = 1'b0;
    next_pa    = va_i;
    next_cache = 1'b0;
    next_wt    = cache_wt_i;
    next_miss  = 1'b0;
    next_err   = 1'b0;
    next_ctrl  = 1'b0;
    next_rdata = 32'h00000000;
    unique case (state)
      ST_IDLE: begin
        if (accept && translated) begin
          next_state = ST_LOOKUP;
        end else if (accept) begin
          next_resp = 1'b1;
          unique case (area)
            AREA_P0, AREA_P3, AREA_U0: begin
              next_cache = cache_enable_i;
            end
            AREA_P1: begin
              next_pa    = va_i & ~`VADMMU_P1_CLEAR;
              next_cache = cache_enable_i;
              next_wt    = ~p1_copy_back_i;
            end
            AREA_P2: begin                               // cache stays off
              next_pa = va_i & `VADMMU_P2_KEEP;
            end
            AREA_P4: begin
              next_ctrl  = 1'b1;
              next_rdata = (reg_hit && !wr_i) ? rd_mux : 32'h00000000;
            end
            AREA_UERR: begin
              next_err = 1'b1;
            end
            default: begin
              next_err = 1'b1;
            end
          endcase
        end
      end
      ST_LOOKUP: begin
        if (tlb_ack_i) begin
          next_state = ST_IDLE;
          next_resp  = 1'b1;
          next_pa    = tlb_pa_i;
          next_cache = tlb_hit_i && cache_enable_i && tlb_cacheable_i;
          next_miss  = !tlb_hit_i;
        end
      end
    endcase
  end

  // ========================================================================
  // sequencer state and ready
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      state   <= ST_IDLE;
      ready_o <= 1'b0;
    end else begin
      state   <= next_state;
      ready_o <= (next_state == ST_IDLE);
    end
  end

  // ========================================================================
  // answer registers; physical address cut to 29 bits so aliases merge
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      resp_valid_o     <= 1'b0;
      pa_o             <= '0;
      cacheable_o      <= 1'b0;
      write_through_o  <= 1'b0;
      cache_tag_addr_o <= 32'h00000000;
      tlb_miss_o       <= 1'b0;
      addr_err_o       <= 1'b0;
      ctrl_space_o     <= 1'b0;
      rdata_o          <= 32'h00000000;
    end else begin
      resp_valid_o <= next_resp;
      if (next_resp) begin
        pa_o             <= next_pa[`VADMMU_PA_W-1:0];
        cacheable_o      <= next_cache;
        write_through_o  <= next_wt;
        // tag address keeps the top three bits at zero
        cache_tag_addr_o <= next_cache ? {3'h0, next_pa[`VADMMU_PA_W-1:0]}
                                       : 32'h00000000;
        tlb_miss_o       <= next_miss;
        addr_err_o       <= next_err;
        ctrl_space_o     <= next_ctrl;
        rdata_o          <= next_rdata;
      end
    end
  end

  // ========================================================================
  // lookup request held until the buffer acknowledges
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      tlb_lookup_o <= 1'b0;
      tlb_vpn_o    <= '0;
      va_hold      <= 32'h00000000;
    end else begin
      if (state == ST_IDLE && accept) begin
        va_hold <= va_i;
      end
      if (state == ST_IDLE && accept && translated) begin
        tlb_lookup_o <= 1'b1;
        tlb_vpn_o    <= va_i[31:`VADMMU_VPN_LSB];
      end else if (tlb_ack_i) begin
        tlb_lookup_o <= 1'b0;
      end
    end
  end

  // ========================================================================
  // privilege bit: set by reset or exception entry, entry beats return
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      privileged_o <= 1'b1;
    end else if (exc_entry_i) begin
      privileged_o <= 1'b1;
    end else if (exc_return_i) begin
      privileged_o <= 1'b0;
    end
  end

  // ========================================================================
  // translation_control: reset clears all but the space select bit
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      at_enable       <= `VADMMU_TCTRL_RESET;
      tlb_index_xor_o <= `VADMMU_TCTRL_RESET;
      tlb_flush_o     <= `VADMMU_TCTRL_RESET;
    end else begin
      tlb_flush_o <= 1'b0;
      if (reg_wr && sel_tctrl) begin
        at_enable       <= wdata_i[`VADMMU_AT_BIT];
        tlb_index_xor_o <= wdata_i[`VADMMU_IX_BIT];
        tlb_flush_o     <= wdata_i[`VADMMU_TF_BIT];
      end
    end
  end

  // space select is not reset: software must set it before use
  always_ff @(posedge clk_i) begin
    if (reg_wr && sel_tctrl) begin
      tlb_single_space_o <= wdata_i[`VADMMU_SV_BIT];
    end
  end

  // ========================================================================
  // data registers have undefined reset values; faults load vpn and address
  always_ff @(posedge clk_i) begin
    if (reg_wr && sel_page_entry_high) begin
      page_entry_high_vpn  <= wdata_i[31:`VADMMU_VPN_LSB];
      tlb_tag_o <= wdata_i[`VADMMU_TAG_W-1:0];   // no flush on tag change
    end else if (next_resp && (next_err || next_miss)) begin
      page_entry_high_vpn  <= (state == ST_LOOKUP) ? va_hold[31:`VADMMU_VPN_LSB]
                                        : va_i[31:`VADMMU_VPN_LSB];
    end
  end

  always_ff @(posedge clk_i) begin
    if (reg_wr && sel_tea) begin
      fault_address_capture <= wdata_i;
    end else if (next_resp && (next_err || next_miss)) begin
      fault_address_capture <= (state == ST_LOOKUP) ? va_hold : va_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reg_wr && sel_page_entry_low) begin
      page_entry_low <= wdata_i;
    end
    if (reg_wr && sel_ttb) begin
      table_base_pointer <= wdata_i;
    end
  end

  // ========================================================================
  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_take_fixed;
    accept && state == ST_IDLE && privileged_o && (area == AREA_P1 || area == AREA_P2);
  endsequence

  sequence s_take_translated;
    accept && state == ST_IDLE && translated;
  endsequence

  chk_user_upper_err: assert property (
    accept && state == ST_IDLE && !privileged_o && va_i[31]
    |=> resp_valid_o && addr_err_o && !tlb_miss_o)
    else $error("user access above half not flagged");

  chk_fixed_no_tlb: assert property (
    s_take_fixed |=> resp_valid_o && !tlb_lookup_o && !tlb_miss_o && !addr_err_o)
    else $error("fixed area touched the buffer");

  chk_uncached_p2: assert property (
    accept && state == ST_IDLE && area == AREA_P2
    |=> !cacheable_o && pa_o == $past(va_i[28:0]))
    else $error("uncached fixed area mapping wrong");

  chk_cached_p1: assert property (
    accept && state == ST_IDLE && area == AREA_P1
    |=> pa_o == $past(va_i[28:0]) && cacheable_o == $past(cache_enable_i)
        && write_through_o == !$past(p1_copy_back_i))
    else $error("cached fixed area mapping wrong");

  chk_passthru_off: assert property (
    accept && state == ST_IDLE && !at_enable && area == AREA_P0
    |=> resp_valid_o && pa_o == $past(va_i[28:0]) && !tlb_lookup_o)
    else $error("pass-through with translation off failed");

  chk_lookup_start: assert property (
    s_take_translated |=> tlb_lookup_o && !resp_valid_o
                          && tlb_vpn_o == $past(va_i[31:10]))
    else $error("translated access did not start a lookup");

  // any buffer delay: the miss answer follows the acknowledging edge
  chk_miss_raise: assert property (
    state == ST_LOOKUP && tlb_ack_i && !tlb_hit_i
    |=> resp_valid_o && tlb_miss_o && fault_address_capture == $past(va_hold))
    else $error("miss not raised or address not captured");

  chk_hit_address: assert property (
    state == ST_LOOKUP && tlb_ack_i && tlb_hit_i
    |=> resp_valid_o && !tlb_miss_o && pa_o == $past(tlb_pa_i[28:0]))
    else $error("hit address not taken from buffer");

  chk_tag_alias: assert property (
    resp_valid_o && cacheable_o
    |-> cache_tag_addr_o == {3'h0, pa_o})
    else $error("cache tag address top bits not cleared");

  chk_priv_entry: assert property (
    exc_entry_i |=> privileged_o)
    else $error("privilege bit not set on entry");

  chk_priv_return: assert property (
    exc_return_i && !exc_entry_i |=> !privileged_o)
    else $error("privilege bit not cleared on return");

endmodule : vadmmu_top

`default_nettype wire

// ---- vadmmu_defines.svh ----
// address map, field positions, reset values and widths of the mmu front end
`ifndef VADMMU_DEFINES_SVH
`define VADMMU_DEFINES_SVH

// ==========================================================================
// virtual area boundaries
`define VADMMU_P1_BASE        32'h80000000
`define VADMMU_P2_BASE        32'ha0000000
`define VADMMU_P3_BASE        32'hc0000000
`define VADMMU_P4_BASE        32'he0000000
`define VADMMU_USER_LIMIT     32'h80000000

// ==========================================================================
// address masks for the fixed areas and the 29-bit physical space
`define VADMMU_P1_CLEAR       32'h80000000
`define VADMMU_P2_KEEP        32'h1fffffff
`define VADMMU_PA_W           29

// ==========================================================================
// register offsets, kept as printed; decode uses the low 28 bits inside p4
`define VADMMU_OFF_TCTRL      32'h0fffffe0
`define VADMMU_OFF_PAGE_ENTRY_HIGH       32'h0ffffff0
`define VADMMU_OFF_PAGE_ENTRY_LOW       32'hfffffff4
`define VADMMU_OFF_TTB        32'h0ffffff8
`define VADMMU_OFF_TEA        32'h0ffffffc
`define VADMMU_DEC_W          28

// ==========================================================================
// translation_control fields and reset value
`define VADMMU_AT_BIT         0
`define VADMMU_TF_BIT         2
`define VADMMU_SV_BIT         8
`define VADMMU_IX_BIT         9
`define VADMMU_TCTRL_RESET    1'b0

// ==========================================================================
// page_entry_high layout
`define VADMMU_TAG_W          8
`define VADMMU_VPN_LSB        10
`define VADMMU_VPN_W          22

`endif

// ---- vadmmu_pkg.sv ----
// types shared by the mmu front end modules
`default_nettype none

package vadmmu_pkg;

  // ========================================================================
  // address area classes; 3'b111 is never produced
  typedef enum logic [2:0] {
    AREA_P0   = 3'b000,  // low_translated_area
    AREA_P1   = 3'b001,  // cached_fixed_area
    AREA_P2   = 3'b010,  // uncached_fixed_area
    AREA_P3   = 3'b011,  // high_translated_area
    AREA_P4   = 3'b100,  // control_space_area
    AREA_U0   = 3'b101,  // user_translated_area
    AREA_UERR = 3'b110   // user access above the half-way boundary
  } vadmmu_area_type;

  // ========================================================================
  // request sequencer states
  typedef enum logic [0:0] {
    ST_IDLE   = 1'b0,
    ST_LOOKUP = 1'b1
  } vadmmu_state_type;

endpackage : vadmmu_pkg

`default_nettype wire

// ---- vadmmu_area_decode.sv ----
// classifies a virtual address into an area by privilege mode
`include "vadmmu_defines.svh"
`default_nettype none

module vadmmu_area_decode
  import vadmmu_pkg::*;
(
  // address and mode
  input  wire logic [31:0]    va_i,
  input  wire logic           privileged_i,
  // classification
  output vadmmu_area_type     area_o
);

  // ========================================================================
  // boundary compare; user mode sees only the lower half
  always_comb begin
    if (!privileged_i) begin
      area_o = (va_i < `VADMMU_USER_LIMIT) ? AREA_U0 : AREA_UERR;
    end else if (va_i < `VADMMU_P1_BASE) begin
      area_o = AREA_P0;
    end else if (va_i < `VADMMU_P2_BASE) begin
      area_o = AREA_P1;
    end else if (va_i < `VADMMU_P3_BASE) begin
      area_o = AREA_P2;
    end else if (va_i < `VADMMU_P4_BASE) begin
      area_o = AREA_P3;
    end else begin
      area_o = AREA_P4;
    end
  end

endmodule : vadmmu_area_decode

`default_nettype wire

// ---- vadmmu_tlb_model.sv ----
// translation buffer stand-in that answers lookups after a chosen delay
`default_nettype none

module vadmmu_tlb_model (
  // clock and lookup request
  input  wire logic        clk_i,
  input  wire logic        lookup_i,
  input  wire logic [21:0] vpn_i,
  input  wire logic [3:0]  delay_i,
  // answer
  output logic             ack_o,
  output logic             hit_o,
  output logic [31:0]      pa_o,
  output logic             cacheable_o
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [3:0] wait_q;
  logic       fire;

  assign fire = lookup_i && !ack_o && (wait_q == delay_i);

  // ==========================================================================
  // answer
  initial begin
    ack_o = 1'b0;
    hit_o = 1'b0;
    pa_o = 32'h5a5a5a5a;
    cacheable_o = 1'b0;
    wait_q = 4'h0;
  end

  // fields flip every cycle outside the ack, so a stale sample never matches
  always @(posedge clk_i) begin
    ack_o <= fire;
    wait_q <= (lookup_i && !ack_o && !fire) ? wait_q + 4'h1 : 4'h0;
    if (fire) begin
      hit_o <= !vpn_i[0];                             // odd pages are unregistered
      pa_o <= {3'b000, vpn_i[18:0], 10'h000};         // never in the upper half
      cacheable_o <= vpn_i[1];
    end else begin
      hit_o <= ~hit_o;
      pa_o <= ~pa_o;
      cacheable_o <= ~cacheable_o;
    end
  end

endmodule : vadmmu_tlb_model

`default_nettype wire

// ---- vadmmu_top_tb.sv ----
// self-checking bench for the mmu front end
`default_nettype none

module vadmmu_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import vadmmu_pkg::*;

  logic        clk_i = 0, rst_n_i = 0, req_i = 0, wr_i = 0;
  logic        exc_entry_i = 0, exc_return_i = 0;
  logic        cache_enable_i = 1, cache_wt_i = 0, p1_copy_back_i = 1;
  logic [31:0] va_i = 0, wdata_i = 0;
  logic [3:0]  delay = 0;
  logic        ready_o, resp_valid_o, cacheable_o, write_through_o, tlb_miss_o;
  logic        addr_err_o, ctrl_space_o, privileged_o, tlb_lookup_o, tlb_flush_o;
  logic        tlb_single_space_o, tlb_index_xor_o, tlb_ack_i, tlb_hit_i, tlb_cacheable_i;
  logic [28:0] pa_o;
  logic [31:0] cache_tag_addr_o, rdata_o, tlb_pa_i;
  logic [21:0] tlb_vpn_o;
  logic [7:0]  tlb_tag_o;
  int          fail_count = 0, n_tests = 0;

  // ==========================================================================
  // design and buffer model
  vadmmu_top dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .req_i(req_i), .va_i(va_i),
    .wr_i(wr_i), .wdata_i(wdata_i), .exc_entry_i(exc_entry_i), .exc_return_i(exc_return_i),
    .ready_o(ready_o), .resp_valid_o(resp_valid_o), .pa_o(pa_o), .cacheable_o(cacheable_o),
    .write_through_o(write_through_o), .cache_tag_addr_o(cache_tag_addr_o),
    .tlb_miss_o(tlb_miss_o), .addr_err_o(addr_err_o), .ctrl_space_o(ctrl_space_o),
    .rdata_o(rdata_o), .privileged_o(privileged_o), .cache_enable_i(cache_enable_i),
    .cache_wt_i(cache_wt_i), .p1_copy_back_i(p1_copy_back_i), .tlb_lookup_o(tlb_lookup_o),
    .tlb_vpn_o(tlb_vpn_o), .tlb_tag_o(tlb_tag_o), .tlb_single_space_o(tlb_single_space_o),
    .tlb_index_xor_o(tlb_index_xor_o), .tlb_flush_o(tlb_flush_o), .tlb_ack_i(tlb_ack_i),
    .tlb_hit_i(tlb_hit_i), .tlb_pa_i(tlb_pa_i), .tlb_cacheable_i(tlb_cacheable_i));

  vadmmu_tlb_model tlb (.clk_i(clk_i), .lookup_i(tlb_lookup_o), .vpn_i(tlb_vpn_o),
    .delay_i(delay), .ack_o(tlb_ack_i), .hit_o(tlb_hit_i), .pa_o(tlb_pa_i),
    .cacheable_o(tlb_cacheable_i));

  // 200 MHz clock
  always #2.5 clk_i = ~clk_i;

  // ==========================================================================
  // tasks
  task automatic finish_test;
    if (fail_count == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : finish_test

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("FAIL %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic hang(input string nm);
    fail_count++;
    $display("FAIL %s expected response seen none", nm);
    finish_test();
  endtask : hang

  // one cpu access, started and ended at a falling edge; answer fields are held after
  task automatic acc(input logic [31:0] va, input logic wr, input logic [31:0] wd);
    int i;
    // one idle cycle keeps req_i from being lowered and raised in one step
    @(negedge clk_i);
    i = 0;
    while (ready_o !== 1'b1) begin
      i++;
      if (i > 20) hang("ready_o");
      @(negedge clk_i);
    end
    va_i = va;
    wr_i = wr;
    wdata_i = wd;
    req_i = 1;
    @(negedge clk_i);
    req_i = 0;
    i = 0;
    while (resp_valid_o !== 1'b1) begin
      i++;
      if (i > 40) hang("resp_valid_o");
      @(negedge clk_i);
    end
  endtask : acc

  // one-cycle exception entry or return
  task automatic exc(input logic entry);
    exc_entry_i = entry;
    exc_return_i = !entry;
    @(negedge clk_i);
    exc_entry_i = 0;
    exc_return_i = 0;
  endtask : exc

  task automatic do_reset;
    rst_n_i = 0;
    repeat (16) @(negedge clk_i);
    rst_n_i = 1;
    @(negedge clk_i);
  endtask : do_reset

  // ==========================================================================
  // main sequence
  initial begin
    do_reset();
    acc(32'hffffffe0, 0, 0); chk("ctrl", 0, rdata_o & ~32'h100);
    chk("privileged_o", 1, privileged_o);
    acc(32'h80001000, 0, 0); chk("p1 pa", 32'h1000, {3'b000, pa_o});
    chk("p1 cacheable", 1, cacheable_o); chk("p1 wt", 0, write_through_o);
    chk("p1 miss", 0, tlb_miss_o);
    acc(32'ha0001000, 0, 0); chk("p2 pa", 32'h1000, {3'b000, pa_o});
    chk("p2 cacheable", 0, cacheable_o); chk("p2 tag", 0, cache_tag_addr_o);
    acc(32'h00001000, 0, 0); chk("p0 pa", 32'h1000, {3'b000, pa_o});
    chk("p0 tag", 32'h1000, cache_tag_addr_o);
    acc(32'hc0001000, 0, 0); chk("p3 pa", 32'h1000, {3'b000, pa_o});
    chk("p3 tag", 32'h1000, cache_tag_addr_o);
    acc(32'he0000100, 0, 0); chk("p4 ctrl", 1, ctrl_space_o);
    chk("p4 cacheable", 0, cacheable_o);
    // undefined-at-reset registers are written before use
    acc(32'hfffffff0, 1, 32'h000000a5);
    chk("tag purge", 0, tlb_flush_o);
    acc(32'hffffffe0, 1, 32'h00000305);
    chk("flush", 1, tlb_flush_o);
    acc(32'hfffffff0, 0, 0); chk("entry high", 32'ha5, rdata_o);
    acc(32'hffffffe0, 0, 0); chk("ctrl", 32'h301, rdata_o);
    chk("single", 1, tlb_single_space_o); chk("ixor", 1, tlb_index_xor_o);
    // translated hits, prompt and slow buffer
    for (int d = 0; d < 10; d += 5) begin
      delay = d[3:0];
      acc(32'h00012800, 0, 0); chk("hit pa", 32'h12800, {3'b000, pa_o});
      chk("hit c", 1, cacheable_o); chk("hit miss", 0, tlb_miss_o);
      chk("hit wt", 0, write_through_o); chk("tag", 32'ha5, tlb_tag_o);
    end
    cache_wt_i = 1;
    acc(32'hc0012800, 0, 0); chk("p3 pa", 32'h12800, {3'b000, pa_o});
    chk("p3 wt", 1, write_through_o);
    acc(32'h00012c00, 0, 0); chk("miss", 1, tlb_miss_o);
    acc(32'hfffffffc, 0, 0); chk("fault", 32'h00012c00, rdata_o);
    exc(0); chk("privileged_o", 0, privileged_o);
    acc(32'h00012800, 0, 0); chk("u0 pa", 32'h12800, {3'b000, pa_o});
    chk("u0 err", 0, addr_err_o);
    acc(32'h80001000, 0, 0); chk("u err", 1, addr_err_o);
    exc(1); chk("privileged_o", 1, privileged_o);
    cache_enable_i = 0;
    acc(32'h80001000, 0, 0); chk("p1 off", 0, cacheable_o);
    // manual reset in mid-run
    do_reset();
    acc(32'hffffffe0, 0, 0); chk("ctrl", 0, rdata_o & ~32'h100);
    finish_test();
  end

endmodule : vadmmu_top_tb

`default_nettype wire
